// >>> design/bhr_recorder.sv
// Branch history recorder: retirement capture, control registers, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Entry holds source, destination, metadata words
// - Newest record always sits in entry zero
// - Enabled retire shifts older down, writes entry zero
// - Depth resets to maximum, software may lower
// - Event record keeps branch before exception/interrupt
// - Freeze status suspends array and event recording
// - Source: own address, interrupt next address
// - Destination is always the actual target
// - Debug, SMI, VM exit/entry never recorded
// - Zero-displacement direct call is not recorded
// - Sysmgmt return recorded if no freeze; src=dst=target
// - Secure mode pauses; debug/secure launch clear enable
// - Capability field reports allowed depth, eight bits
// - Depth write zeroes entries, event record kept
// - Entry access at or above depth faults
// - Bulk save/restore touch only entries below depth
// - Kernel bit allows level 0, user higher levels
// - Call-stack mode: near return pops entry zero
module bhr_recorder
    import bhr_pkg::*;
#(
    parameter int N  = 32,
    parameter int AW = 32
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Retirement stage
    input  wire logic        ret_valid,
    input  wire logic [3:0]  ret_kind,
    input  wire logic        ret_disp_zero,
    input  wire logic [1:0]  ret_priv,
    input  wire logic [AW-1:0] ret_cur_addr,
    input  wire logic [AW-1:0] ret_next_addr,
    input  wire logic [AW-1:0] ret_target_addr,
    input  wire logic [31:0] ret_meta,
    // Core status
    input  wire logic        freeze_req,
    input  wire logic        secure_mode,
    input  wire logic        disable_req,
    // Fault report
    output logic             protection_fault
);
    localparam int IW = $clog2(N);
    localparam logic [IW:0] DEPTH_MAX = (IW+1)'(N);

    logic [3:0]    ctrl_q;
    logic [IW:0]   depth_q;
    logic          frz_sm_q;
    logic          frz_q;
    logic          fault_q;
    logic [AW-1:0] ev_src_q, ev_dst_q;
    logic [31:0]   ev_md_q;
    logic [AW-1:0] lb_src_q, lb_dst_q;
    logic [31:0]   lb_md_q;
    logic          ap_q;
    logic          ap_wr_q;
    logic [31:0]   ap_addr_q;
    logic [AW-1:0] m_src, m_dst;
    logic [31:0]   m_md;

    // Entry region decode, used for the read index and the data phase
    function automatic logic in_entry(input logic [31:0] a);
        return a >= 32'(OFF_ENTRY) && a < 32'(OFF_ENTRY) + 32'(N << ENT_SHIFT)
               && a[3:2] != 2'h3;
    endfunction

    function automatic logic [IW-1:0] ent_idx(input logic [31:0] a);
        return IW'((a - 32'(OFF_ENTRY)) >> ENT_SHIFT);
    endfunction

    // Bus phases; the data phase is the cycle with ap_q set
    logic          accept, wr_go, ent_hit, ent_ok;
    assign accept  = hsel && hready && htrans == HTRANS_NSQ;
    assign wr_go   = ap_q && ap_wr_q;
    assign ent_hit = ap_q && in_entry(ap_addr_q);
    assign ent_ok  = ent_hit && {1'b0, ent_idx(ap_addr_q)} < depth_q;

    function automatic logic reg_hit(input logic [11:0] off);
        return wr_go && ap_addr_q == 32'(off);
    endfunction

    // Retirement classification
    logic          priv_ok, rec_on, do_push, do_pop, is_event;
    logic [AW-1:0] p_src, p_dst;
    bhr_kind_t k;
    assign k = bhr_kind_t'(ret_kind);
    assign priv_ok = (ret_priv == 2'h0) ? ctrl_q[CB_KERN] : ctrl_q[CB_USER];
    // Secure mode only pauses; enable itself is untouched
    assign rec_on = ret_valid && ctrl_q[CB_EN] && !frz_q && !secure_mode
                    && priv_ok;

    always_comb
    begin
        do_push  = 1'b0;
        do_pop   = 1'b0;
        is_event = 1'b0;
        p_src    = (k == K_INTR) ? ret_next_addr : ret_cur_addr;
        p_dst    = ret_target_addr;
        case (k)
            K_BRANCH:  do_push = rec_on;
            K_DCALL:   do_push = rec_on && !ret_disp_zero;
            K_NRET:
            begin
                do_pop  = rec_on && ctrl_q[CB_CSTK];
                do_push = rec_on && !ctrl_q[CB_CSTK];
            end
            K_EXCEPT, K_INTR, K_SOFTINT:
            begin
                do_push  = rec_on;
                is_event = rec_on;
            end
            K_SMRET:
            begin
                do_push = rec_on && !frz_sm_q;
                p_src   = ret_target_addr;
            end
            default:   do_push = 1'b0;
        endcase
    end

    bhr_rec_mem #(
        .N  (N),
        .AW (AW),
        .IW (IW)
    ) u_mem (
        .mclk     (mclk),
        .rstn     (rstn),
        .ce       (ce),
        .clr      (reg_hit(OFF_DEPTH)),
        .push     (do_push),
        .pop      (do_pop),
        .depth    (depth_q),
        .push_src (p_src),
        .push_dst (p_dst),
        .push_md  (ret_meta),
        .wr       (wr_go && ent_ok),
        .wr_idx   (ent_idx(ap_addr_q)),
        .wr_field (ap_addr_q[3:2]),
        .wr_data  (hwdata),
        .rd_idx   (ent_idx(haddr)),
        .rd_src_q (m_src),
        .rd_dst_q (m_dst),
        .rd_md_q  (m_md)
    );

    // Control register; hardware disable wins over a same-cycle software set
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            ctrl_q <= '0;
        else if (ce)
        begin
            if (reg_hit(OFF_CTRL))
                ctrl_q <= hwdata[3:0];
            if (disable_req || (ret_valid && k == K_DEBUG))
                ctrl_q[CB_EN] <= 1'b0;
        end
    end

    // Depth: zero or oversize writes load the maximum
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            depth_q <= DEPTH_MAX;
        else if (ce && reg_hit(OFF_DEPTH))
            depth_q <= (hwdata == 32'h0 || hwdata > 32'(N)) ? DEPTH_MAX : hwdata[IW:0];
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            frz_sm_q <= 1'b0;
        else if (ce && reg_hit(OFF_DBGCTL))
            frz_sm_q <= hwdata[DB_FRZ_SM];
    end

    // Freeze status: core request wins over a software clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            frz_q <= 1'b0;
        else if (ce)
        begin
            if (freeze_req)
                frz_q <= 1'b1;
            else if (reg_hit(OFF_PERF))
                frz_q <= hwdata[PB_FRZ];
        end
    end

    // Last recorded branch, snapshot source for the event record
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lb_src_q <= '0;
            lb_dst_q <= '0;
            lb_md_q  <= '0;
        end
        else if (ce && do_push && !is_event)
        begin
            lb_src_q <= p_src;
            lb_dst_q <= p_dst;
            lb_md_q  <= ret_meta;
        end
    end

    // Event record; depth writes leave it alone
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ev_src_q <= '0;
            ev_dst_q <= '0;
            ev_md_q  <= '0;
        end
        else if (ce)
        begin
            if (is_event)
            begin
                ev_src_q <= lb_src_q;
                ev_dst_q <= lb_dst_q;
                ev_md_q  <= lb_md_q;
            end
            else
            begin
                if (reg_hit(OFF_EV_SRC))
                    ev_src_q <= hwdata[AW-1:0];
                if (reg_hit(OFF_EV_DST))
                    ev_dst_q <= hwdata[AW-1:0];
                if (reg_hit(OFF_EV_MD))
                    ev_md_q <= hwdata;
            end
        end
    end

    // Fault flag: a new fault wins over a write-one clear
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            fault_q          <= 1'b0;
            protection_fault <= 1'b0;
        end
        else if (ce)
        begin
            protection_fault <= ent_hit && !ent_ok;
            if (ent_hit && !ent_ok)
                fault_q <= 1'b1;
            else if (reg_hit(OFF_FAULT) && hwdata[FB_FAULT])
                fault_q <= 1'b0;
        end
    end

    // Every transfer takes one wait state so read data leave a flop
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ap_q      <= 1'b0;
            ap_wr_q   <= 1'b0;
            ap_addr_q <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
            if (accept)
            begin
                ap_q      <= 1'b1;
                ap_wr_q   <= hwrite;
                ap_addr_q <= haddr;
                hreadyout <= 1'b0;
            end
            else if (ap_q)
            begin
                ap_q      <= 1'b0;
                hreadyout <= 1'b1;
            end
        end
    end

    // Read data; writes leave it, faulted and unmapped reads return zero
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            hrdata <= '0;
        else if (ce && ap_q && !ap_wr_q)
        begin
            hrdata <= '0;
            if (ent_hit)
            begin
                if (ent_ok)
                    hrdata <= (ap_addr_q[3:2] == FLD_SRC) ? 32'(m_src) :
                              (ap_addr_q[3:2] == FLD_DST) ? 32'(m_dst) : m_md;
            end
            else
            begin
                case (ap_addr_q[11:0])
                    OFF_CTRL:   hrdata <= 32'(ctrl_q);
                    OFF_DEPTH:  hrdata <= 32'(depth_q);
                    OFF_DBGCTL: hrdata <= 32'(frz_sm_q);
                    OFF_PERF:   hrdata <= 32'(frz_q);
                    OFF_CAP:    hrdata <= 32'(CAP_W'(N));
                    OFF_FAULT:  hrdata <= 32'(fault_q) | (32'(secure_mode) << FB_SECURE);
                    OFF_EV_SRC: hrdata <= 32'(ev_src_q);
                    OFF_EV_DST: hrdata <= 32'(ev_dst_q);
                    OFF_EV_MD:  hrdata <= ev_md_q;
                    default:    hrdata <= '0;
                endcase
                if (ap_addr_q[31:12] != 20'h0)
                    hrdata <= '0;
            end
        end
    end
endmodule

`default_nettype wire

// >>> design/bhr_rec_mem.sv
// Package and age-ordered record array for the branch history recorder
`timescale 1ns/1ps
`default_nettype none

package bhr_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_DEPTH  = 12'h004;
    localparam logic [11:0] OFF_DBGCTL = 12'h008;
    localparam logic [11:0] OFF_PERF   = 12'h00c;
    localparam logic [11:0] OFF_CAP    = 12'h010;
    localparam logic [11:0] OFF_FAULT  = 12'h014;
    localparam logic [11:0] OFF_EV_SRC = 12'h020;
    localparam logic [11:0] OFF_EV_DST = 12'h024;
    localparam logic [11:0] OFF_EV_MD  = 12'h028;
    localparam logic [11:0] OFF_ENTRY  = 12'h100;
    localparam int          ENT_SHIFT  = 4;
    // Entry word fields
    localparam logic [1:0]  FLD_SRC    = 2'h0;
    localparam logic [1:0]  FLD_DST    = 2'h1;
    localparam logic [1:0]  FLD_MD     = 2'h2;
    // Register bit positions and capability field width
    localparam int          CB_EN      = 0;
    localparam int          CB_CSTK    = 1;
    localparam int          CB_KERN    = 2;
    localparam int          CB_USER    = 3;
    localparam int          DB_FRZ_SM  = 0;
    localparam int          PB_FRZ     = 0;
    localparam int          FB_FAULT   = 0;
    localparam int          FB_SECURE  = 8;
    localparam int          CAP_W      = 8;
    // AHB encodings
    localparam logic [1:0]  HTRANS_NSQ = 2'h2;
    // Retired operation kinds
    typedef enum logic [3:0] {
        K_BRANCH, K_DCALL, K_NRET, K_EXCEPT, K_INTR, K_SOFTINT,
        K_DEBUG, K_SMI, K_VMEXIT, K_VMENTRY, K_SMRET
    } bhr_kind_t;
endpackage

module bhr_rec_mem
    import bhr_pkg::*;
#(
    parameter int N  = 32,
    parameter int AW = 32,
    parameter int IW = 5
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          ce,
    // Array operations
    input  wire logic          clr,
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [IW:0]   depth,
    input  wire logic [AW-1:0] push_src,
    input  wire logic [AW-1:0] push_dst,
    input  wire logic [31:0]   push_md,
    // Software word write
    input  wire logic          wr,
    input  wire logic [IW-1:0] wr_idx,
    input  wire logic [1:0]    wr_field,
    input  wire logic [31:0]   wr_data,
    // Registered read
    input  wire logic [IW-1:0] rd_idx,
    output logic [AW-1:0]      rd_src_q,
    output logic [AW-1:0]      rd_dst_q,
    output logic [31:0]        rd_md_q
);
    logic [AW-1:0] src_q [N];
    logic [AW-1:0] dst_q [N];
    logic [31:0]   md_q  [N];

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_ent
            localparam int P = (i == 0) ? 0 : i - 1;
            localparam int Q = (i == N - 1) ? i : i + 1;
            localparam logic [IW:0] IDX = (IW+1)'(i);
            always_ff @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    src_q[i] <= '0;
                    dst_q[i] <= '0;
                    md_q[i]  <= '0;
                end
                else if (ce)
                begin
                    if (clr)
                    begin
                        src_q[i] <= '0;
                        dst_q[i] <= '0;
                        md_q[i]  <= '0;
                    end
                    // Entries at or above depth never move, so they stay zero
                    else if (push && IDX < depth)
                    begin
                        src_q[i] <= (i == 0) ? push_src : src_q[P];
                        dst_q[i] <= (i == 0) ? push_dst : dst_q[P];
                        md_q[i]  <= (i == 0) ? push_md  : md_q[P];
                    end
                    else if (pop && IDX < depth)
                    begin
                        src_q[i] <= (IDX == depth - 1'b1) ? '0 : src_q[Q];
                        dst_q[i] <= (IDX == depth - 1'b1) ? '0 : dst_q[Q];
                        md_q[i]  <= (IDX == depth - 1'b1) ? '0 : md_q[Q];
                    end
                    else if (wr && wr_idx == IDX[IW-1:0])
                    begin
                        if (wr_field == FLD_SRC)
                            src_q[i] <= wr_data[AW-1:0];
                        if (wr_field == FLD_DST)
                            dst_q[i] <= wr_data[AW-1:0];
                        if (wr_field == FLD_MD)
                            md_q[i] <= wr_data;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_src_q <= '0;
            rd_dst_q <= '0;
            rd_md_q  <= '0;
        end
        else if (ce)
        begin
            rd_src_q <= src_q[rd_idx];
            rd_dst_q <= dst_q[rd_idx];
            rd_md_q  <= md_q[rd_idx];
        end
    end
endmodule

`default_nettype wire

// >>> tb/bhr_recorder_properties.sv
// Bus and fault timing checker for the branch history recorder
`timescale 1ns/1ps
`default_nettype none

module bhr_recorder_props
    import bhr_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hreadyout,
    input  wire logic [31:0] hrdata,
    input  wire logic        hresp,
    // Fault
    input  wire logic        protection_fault
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_wait_one: assert property (
        ce && hsel && hreadyout && htrans == HTRANS_NSQ |=> !hreadyout ##1 hreadyout)
        else $error("wait state not exactly one cycle");
    a_wait_cause: assert property (
        !hreadyout |-> $past(hsel) && $past(htrans) == HTRANS_NSQ)
        else $error("wait state without a request");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_fault_pulse: assert property (protection_fault |=> !protection_fault)
        else $error("fault pulse longer than one cycle");
    a_fault_at_end: assert property (
        protection_fault |-> hreadyout && !$past(hreadyout))
        else $error("fault pulse not at end of transfer");
    a_fault_entry: assert property (
        protection_fault |-> $past(haddr, 2) >= {20'h0, OFF_ENTRY})
        else $error("fault on a non-entry address");
    a_rdata_hold: assert property (
        hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved while idle");
    a_reset_clear: assert property (
        $rose(rstn) |-> hrdata == 32'h0 && hreadyout && !protection_fault)
        else $error("outputs not cleared by reset");
endmodule

bind bhr_recorder bhr_recorder_props u_props (
    .mclk(mclk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .protection_fault(protection_fault)
);
`default_nettype wire

// >>> tb/bhr_core_model.sv
// Retirement stage model feeding operations to the recorder
`timescale 1ns/1ps
`default_nettype none

module bhr_core_model (
    // Clock
    input  wire logic         mclk,
    // Retired operation
    output logic              ret_valid,
    output logic [3:0]        ret_kind,
    output logic              ret_disp_zero,
    output logic [1:0]        ret_priv,
    output logic [31:0]       ret_cur_addr,
    output logic [31:0]       ret_next_addr,
    output logic [31:0]       ret_target_addr,
    output logic [31:0]       ret_meta
);
    initial
    begin
        {ret_valid, ret_kind, ret_disp_zero, ret_priv} = 8'h0;
        {ret_cur_addr, ret_next_addr, ret_target_addr, ret_meta} = 128'h0;
    end

    // Gap 0 keeps valid high so the next call retires back to back
    task automatic op(input logic [3:0] k, input logic dz, input logic [1:0] pv,
                      input logic [31:0] c, n, t, m, input int gap);
        ret_valid <= 1'b1;
        {ret_kind, ret_disp_zero, ret_priv} <= {k, dz, pv};
        {ret_cur_addr, ret_next_addr, ret_target_addr, ret_meta} <= {c, n, t, m};
        @(posedge mclk);
        if (gap > 0)
        begin
            ret_valid <= 1'b0;
            // Idle address and meta fields never repeat the last op; kind, displacement and privilege hold
            {ret_cur_addr, ret_next_addr, ret_target_addr, ret_meta} <= ~{c, n, t, m};
            repeat (gap) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> tb/bhr_recorder_tb.sv
// Self-checking testbench for the branch history recorder
`timescale 1ns/1ps
`default_nettype none

module bhr_recorder_tb
    import bhr_pkg::*;
;
    localparam int N = 32;
    logic mclk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, in_data = 1'b0;
    logic freeze_req = 1'b0, secure_mode = 1'b0, disable_req = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h3a20;
    logic [1:0]  htrans = 2'h0;
    logic        hreadyout, hresp, protection_fault, ret_valid, ret_disp_zero;
    logic [3:0]  ret_kind, ctl = 4'h0;
    logic [1:0]  ret_priv;
    logic [31:0] ret_cur_addr, ret_next_addr, ret_target_addr, ret_meta, hrdata;
    logic [95:0] ent [N];
    logic [95:0] ev = 96'h0, ls = 96'h0;
    logic [33:0] exp_q [$];
    logic [33:0] e;
    logic        frz = 1'b0, frz_sm = 1'b0;
    int          dep = N, n_mismatch = 0, check_count = 0;

    always #5 mclk = ~mclk;

    bhr_recorder #(.N(N), .AW(32)) DUT (
        .mclk(mclk), .rstn(rstn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ret_valid(ret_valid),
        .ret_kind(ret_kind), .ret_disp_zero(ret_disp_zero), .ret_priv(ret_priv),
        .ret_cur_addr(ret_cur_addr), .ret_next_addr(ret_next_addr),
        .ret_target_addr(ret_target_addr), .ret_meta(ret_meta), .freeze_req(freeze_req),
        .secure_mode(secure_mode), .disable_req(disable_req),
        .protection_fault(protection_fault));

    bhr_core_model core (
        .mclk(mclk), .ret_valid(ret_valid), .ret_kind(ret_kind),
        .ret_disp_zero(ret_disp_zero), .ret_priv(ret_priv), .ret_cur_addr(ret_cur_addr),
        .ret_next_addr(ret_next_addr), .ret_target_addr(ret_target_addr),
        .ret_meta(ret_meta));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [11:0] ea(input int i, input int f);
        return OFF_ENTRY + 12'(i << ENT_SHIFT) + 12'(4 * f);
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (exp_q.size() != 0)
            n_mismatch++;
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One single word transfer; read data expectation goes to the queue
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic f);
        @(posedge mclk);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, HTRANS_NSQ, 20'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        in_data <= 1'b1;
        exp_q.push_back({!w, f, d});
        do @(posedge mclk); while (hreadyout !== 1'b1);
        in_data <= 1'b0;
    endtask

    task automatic set_ctl(input logic [3:0] v);
        xfer(1'b1, OFF_CTRL, {28'h0, v}, 1'b0);
        ctl = v;
    endtask

    task automatic chk_ent(input int n);
        for (int i = 0; i < n; i++)
            for (int f = 0; f < 3; f++)
                xfer(1'b0, ea(i, f), ent[i][95 - 32 * f -: 32], 1'b0);
    endtask

    // Retire one operation and update the reference array
    task automatic retire(input logic [3:0] k, input logic [1:0] pv, input logic dz,
                          input int gap);
        logic [31:0] c, t, m, s;
        logic        rec;
        c = xs();
        t = xs();
        m = xs();
        core.op(k, dz, pv, c, c + 32'h4, t, m, gap);
        rec = ctl[0] && !frz && !secure_mode && (pv == 2'h0 ? ctl[2] : ctl[3]);
        rec = rec && !(k inside {[4'h6:4'h9]}) && !(k == 4'h1 && dz);
        rec = rec && !(k == 4'ha && frz_sm);
        if (k == 4'h6)
            ctl[0] = 1'b0;
        if (rec && k == 4'h2 && ctl[1])
        begin
            for (int i = 0; i < N; i++)
                ent[i] = (i < dep - 1) ? ent[i + 1] : 96'h0;
        end
        else if (rec)
        begin
            s = (k == 4'h4) ? c + 32'h4 : ((k == 4'ha) ? t : c);
            if (k inside {[4'h3:4'h5]})
                ev = ls;
            else
                ls = {s, t, m};
            for (int i = N - 1; i > 0; i--)
                ent[i] = (i < dep) ? ent[i - 1] : 96'h0;
            ent[0] = {s, t, m};
        end
    endtask

    always @(posedge mclk)
        if (in_data && hreadyout === 1'b1)
        begin
            e = exp_q.pop_front();
            check("fault", {31'h0, protection_fault}, {31'h0, e[32]});
            if (e[33])
                check("rdata", hrdata, e[31:0]);
        end

    initial
    begin
        #100_000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        logic [31:0] x;
        ent = '{default: 96'h0};
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        xfer(1'b0, OFF_CTRL, 32'h0, 1'b0);
        xfer(1'b0, OFF_DEPTH, 32'(N), 1'b0);
        xfer(1'b0, OFF_CAP, 32'(N), 1'b0);
        xfer(1'b0, OFF_EV_SRC, 32'h0, 1'b0);
        xfer(1'b0, 12'h0fc, 32'h0, 1'b0);
        xfer(1'b0, ea(0, 3), 32'h0, 1'b0);
        set_ctl(4'h5);
        for (int j = 0; j < 48; j++)
        begin
            if (j == 24)
                set_ctl(4'hd);
            x = xs();
            retire(x[7:0] % 11 == 6 ? 4'h0 : 4'(x[7:0] % 11), x[9:8], x[12],
                   (j % 24 == 23) ? 1 : int'(x[17:16] % 3));
        end
        chk_ent(N);
        for (int f = 0; f < 3; f++)
            xfer(1'b0, OFF_EV_SRC + 12'(4 * f), ev[95 - 32 * f -: 32], 1'b0);
        xfer(1'b1, OFF_PERF, 32'h1, 1'b0);
        frz = 1'b1;
        retire(4'h0, 2'h0, 1'b0, 1);
        xfer(1'b1, OFF_PERF, 32'h0, 1'b0);
        freeze_req <= 1'b1;
        @(posedge mclk);
        freeze_req <= 1'b0;
        xfer(1'b0, OFF_PERF, 32'h1, 1'b0);
        retire(4'h3, 2'h0, 1'b0, 1);
        xfer(1'b1, OFF_PERF, 32'h0, 1'b0);
        frz = 1'b0;
        secure_mode <= 1'b1;
        retire(4'h0, 2'h0, 1'b0, 1);
        xfer(1'b0, OFF_FAULT, 32'h100, 1'b0);
        secure_mode <= 1'b0;
        xfer(1'b1, OFF_DBGCTL, 32'h1, 1'b0);
        frz_sm = 1'b1;
        retire(4'ha, 2'h0, 1'b0, 1);
        retire(4'h6, 2'h0, 1'b0, 1);
        xfer(1'b0, OFF_CTRL, {28'h0, ctl}, 1'b0);
        set_ctl(4'h5);
        disable_req <= 1'b1;
        @(posedge mclk);
        disable_req <= 1'b0;
        ctl[0] = 1'b0;
        xfer(1'b0, OFF_CTRL, {28'h0, ctl}, 1'b0);
        set_ctl(4'h7);
        retire(4'h2, 2'h0, 1'b0, 1);
        chk_ent(2);
        xfer(1'b0, ea(N - 1, 0), 32'h0, 1'b0);
        xfer(1'b1, OFF_DEPTH, 32'h4, 1'b0);
        dep = 4;
        ent = '{default: 96'h0};
        xfer(1'b0, OFF_DEPTH, 32'h4, 1'b0);
        chk_ent(1);
        xfer(1'b0, OFF_EV_SRC, ev[95:64], 1'b0);
        set_ctl(4'h5);
        for (int j = 0; j < 5; j++)
            retire(4'h0, 2'h0, 1'b0, int'(j == 4));
        xfer(1'b1, ea(3, 1), 32'h5a5a_0000, 1'b0);
        ent[3][63:32] = 32'h5a5a_0000;
        chk_ent(4);
        xfer(1'b0, ea(4, 0), 32'h0, 1'b1);
        xfer(1'b1, ea(4, 1), 32'h1234_5678, 1'b1);
        xfer(1'b0, OFF_FAULT, 32'h1, 1'b0);
        xfer(1'b1, OFF_FAULT, 32'h1, 1'b0);
        xfer(1'b0, OFF_FAULT, 32'h0, 1'b0);
        xfer(1'b1, OFF_DEPTH, 32'h0, 1'b0);
        xfer(1'b0, OFF_DEPTH, 32'(N), 1'b0);
        repeat (2) @(posedge mclk);
        end_sim();
    end
endmodule
`default_nettype wire
